/* hw/pin_sync.v */
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 3,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Asynchronous levels in, synchronised levels out
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // pin_sync

/* hw/serial_host_chain_interface.v */
// Serial host chain interface: shift-clock slave, chain identifier, passthrough and AXI-Lite
// Summary of operation
// - Access is two command words plus data
// - Select falling starts, rising ends an access
// - Four clock read turnaround before first data; code shifts first bit out on the falling edge after the command words
// - Later auto-increment read words follow back to back
// - Auto-increment advances address each word until deselect
// - Up to 32 devices share one select
// - Reset clears identifier and enables passthrough
// - Identifier zero write with disable breaks passthrough
// - Unassigned device takes identifier, restores passthrough
// - Reads only when target identifier matches; writes on match or broadcast
// - Command word field layout as specified
// - Sample on rising, shift out on falling
// - Passthrough disabled holds serial output high
// - Shared output floats while select is high
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "serial_host_chain_map.vh"
module serial_host_chain_interface #(
  parameter REG_DEPTH = 64,
  parameter IDX_W = 6
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [31:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // AXI4-Lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [31:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Serial link pins
  input wire shift_clock,
  input wire select_n,
  input wire serial_in,
  output wire serial_out,
  output wire serial_out_oe_n
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD1 = 3'd1;
  localparam [2:0] ST_CMD2 = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_IGNORE = 3'd5;

  // Synchronised pins
  wire [2:0] pins_s;
  wire sclk_s;
  wire sel_n_s;
  wire sdi_s;

  pin_sync #(
    .W(3),
    .INIT(3'b010)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({shift_clock, select_n, serial_in}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign sel_n_s = pins_s[1];
  assign sdi_s = pins_s[0];

  reg sclk_prev_q;
  reg sel_prev_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg [15:0] cmd1_q;
  reg [22:0] addr_q;
  reg auto_increment_q;
  reg [15:0] tx_q;
  reg so_q;
  reg read_drv_q;
  reg pass_dis_q;
  reg shared_out_q;
  reg [4:0] chain_id_q;
  reg [15:0] write_count_q;
  reg [15:0] mem [0:REG_DEPTH-1];

  wire sclk_rise = sclk_s & ~sclk_prev_q & ~sel_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev_q & ~sel_n_s;
  wire frame_start = sel_prev_q & ~sel_n_s;
  wire frame_end = ~sel_prev_q & sel_n_s;
  wire [15:0] shift_d = {shift_q[14:0], sdi_s};
  wire word_done = sclk_rise & (bit_cnt_q == `LAST_BIT);

  // Decode of command word 1 once the second word completes
  wire [22:0] cmd_addr = {cmd1_q[`CMD1_UADDR_HI:0], shift_d};
  wire cmd_read = cmd1_q[`CMD1_READ_BIT];
  wire cmd_bcast = cmd1_q[`CMD1_BCAST_BIT];
  wire cmd_ext = cmd1_q[`CMD1_EXT_ADDR_BIT];
  wire [4:0] cmd_id = cmd1_q[`CMD1_ID_HI:`CMD1_ID_LO];
  wire id_match = (cmd_id == chain_id_q);
  wire wr_accept = cmd_ext & ~cmd_read & (id_match | cmd_bcast);
  wire rd_accept = cmd_ext & cmd_read & id_match;

  // Serial write strobe and target
  wire ser_wr = (state_q == ST_WDATA) & word_done & ~frame_end;
  wire ser_wr_ctrl = ser_wr & (addr_q == `CTRL_REG_ADDR);
  wire ser_wr_mem = ser_wr & (addr_q != `CTRL_REG_ADDR) & (addr_q < REG_DEPTH);
  wire [22:0] addr_next = addr_q + 23'h000001;

  wire [15:0] ctrl_word = {pass_dis_q, shared_out_q, 9'h000, chain_id_q};

  // Register contents seen by a serial read
  function [15:0] rd_word;
    input [22:0] a;
    begin
      if (a == `CTRL_REG_ADDR) begin
        rd_word = ctrl_word;
      end else if (a < REG_DEPTH) begin
        rd_word = mem[a[IDX_W-1:0]];
      end else begin
        rd_word = 16'h0000;
      end
    end
  endfunction

  // Link framing and shifting
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      cmd1_q <= 16'h0000;
      addr_q <= 23'h000000;
      auto_increment_q <= 1'b0;
      tx_q <= 16'h0000;
      so_q <= 1'b1;
      read_drv_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q <= sel_n_s;
      if (frame_start) begin
        state_q <= ST_CMD1;
        bit_cnt_q <= 4'h0;
        read_drv_q <= 1'b0;
      end else if (frame_end) begin
        state_q <= ST_IDLE;
        bit_cnt_q <= 4'h0;
        read_drv_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_q <= shift_d;
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (word_done) begin
          case (state_q)
            ST_CMD1: begin
              cmd1_q <= shift_d;
              state_q <= ST_CMD2;
            end
            ST_CMD2: begin
              addr_q <= cmd_addr;
              auto_increment_q <= cmd1_q[`CMD1_AUTO_INCREMENT_BIT];
              if (rd_accept) begin
                tx_q <= rd_word(cmd_addr);
                read_drv_q <= 1'b1;
                state_q <= ST_RDATA;
              end else if (wr_accept) begin
                state_q <= ST_WDATA;
              end else begin
                state_q <= ST_IGNORE;
              end
            end
            ST_WDATA: begin
              if (auto_increment_q) begin
                addr_q <= addr_next;
              end else begin
                state_q <= ST_IGNORE;
              end
            end
            ST_RDATA: begin
              if (auto_increment_q) begin
                addr_q <= addr_next;
                tx_q <= rd_word(addr_next);
              end else begin
                state_q <= ST_IGNORE;
              end
            end
            default: begin
              state_q <= state_q;
            end
          endcase
        end
        if (sclk_fall && read_drv_q) begin
          so_q <= tx_q[15];
          tx_q <= {tx_q[14:0], 1'b0};
        end
      end
    end
  end

  // Register file reached over the link
  always @(posedge aclk) begin
    if (ser_wr_mem) begin
      mem[addr_q[IDX_W-1:0]] <= shift_d;
    end
  end

  // AXI4-Lite write path
  reg aw_got_q;
  reg w_got_q;
  reg [3:0] wa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  wire axi_wr = aw_got_q & w_got_q & ~bvalid_q;
  wire axi_wr_ctrl = axi_wr & (wa_q == `OFS_CONTROL);

  assign awready = ~aw_got_q & ~bvalid_q;
  assign wready = ~w_got_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wa_q <= 4'h0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        wa_q <= awaddr[3:0];
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (axi_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (wa_q == `OFS_CONTROL) begin
          bresp_q <= `RESP_OKAY;
        end else if (wa_q == `OFS_STATUS || wa_q == `OFS_LAST_ADDR) begin
          bresp_q <= `RESP_OKAY;
        end else if (wa_q == `OFS_WRITE_COUNT) begin
          bresp_q <= `RESP_OKAY;
        end else begin
          bresp_q <= `RESP_SLVERR;
        end
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control register: link write wins over local bus write
  always @(posedge aclk) begin
    if (!aresetn) begin
      pass_dis_q <= `RST_PASS_DIS;
      shared_out_q <= `RST_SHARED_OUT;
      chain_id_q <= `RST_CHAIN_ID;
      write_count_q <= 16'h0000;
    end else begin
      if (ser_wr) begin
        write_count_q <= write_count_q + 16'h0001;
      end
      if (ser_wr_ctrl) begin
        pass_dis_q <= shift_d[`CTRL_PASS_DIS_BIT];
        shared_out_q <= shift_d[`CTRL_SHARED_OUT_BIT];
        chain_id_q <= shift_d[`CTRL_ID_HI:`CTRL_ID_LO];
      end else if (axi_wr_ctrl) begin
        if (ws_q[1]) begin
          pass_dis_q <= wd_q[`CTRL_PASS_DIS_BIT];
          shared_out_q <= wd_q[`CTRL_SHARED_OUT_BIT];
        end
        if (ws_q[0]) begin
          chain_id_q <= wd_q[`CTRL_ID_HI:`CTRL_ID_LO];
        end
      end
    end
  end

  // AXI4-Lite read path
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire [3:0] ra = araddr[3:0];

  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `RESP_OKAY;
      if (ra == `OFS_CONTROL) begin
        rdata_q <= {16'h0000, ctrl_word};
      end else if (ra == `OFS_STATUS) begin
        rdata_q <= {22'h000000, sel_n_s, read_drv_q, bit_cnt_q, 2'b00, state_q[1:0]};
      end else if (ra == `OFS_LAST_ADDR) begin
        rdata_q <= {9'h000, addr_q};
      end else if (ra == `OFS_WRITE_COUNT) begin
        rdata_q <= {16'h0000, write_count_q};
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= `RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Serial output: read data, else non-clocked passthrough or held high
  assign serial_out = read_drv_q ? so_q : (pass_dis_q ? 1'b1 : serial_in);
  assign serial_out_oe_n = shared_out_q & sel_n_s;
endmodule // serial_host_chain_interface

/* hw/serial_host_chain_map.vh */
// Offsets, field positions, reset values and timing figures of the serial chain interface
`ifndef SERIAL_HOST_CHAIN_MAP_VH
`define SERIAL_HOST_CHAIN_MAP_VH

// Local bus register byte offsets
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_LAST_ADDR 4'h8
`define OFS_WRITE_COUNT 4'hC

// Command word 1 fields
`define CMD1_READ_BIT 15
`define CMD1_BCAST_BIT 14
`define CMD1_EXT_ADDR_BIT 13
`define CMD1_AUTO_INCREMENT_BIT 12
`define CMD1_ID_HI 11
`define CMD1_ID_LO 7
`define CMD1_UADDR_HI 6

// Serial interface control register and its fields
`define CTRL_REG_ADDR 23'h000000
`define CTRL_PASS_DIS_BIT 15
`define CTRL_SHARED_OUT_BIT 14
`define CTRL_ID_HI 4
`define CTRL_ID_LO 0

// Reset values
`define RST_CHAIN_ID 5'h00
`define RST_PASS_DIS 1'b0
`define RST_SHARED_OUT 1'b0

// Word framing
`define WORD_BITS 16
`define LAST_BIT 4'hF

// Link timing figures: maximum shift-clock rate in MHz, gaps and turnaround in shift-clock cycles
`define LINK_MAX_MHZ 27
`define GAP_CYCLES 3
`define CONFIG_GAP_CYCLES 4
`define TURNAROUND_CYCLES 4

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* sim/link_chk_sva.sv */
// Port assertions for the serial host chain interface
`timescale 1ns/100ps
module link_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  // Link pins
  input wire shift_clock,
  input wire select_n,
  input wire serial_in,
  input wire serial_out,
  input wire serial_out_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence link_rise;
    $rose(shift_clock);
  endsequence
  write_resp_a: assert property (both_taken |=> ##1 bvalid)
    else $error("late write response");
  ready_drop_a: assert property (both_taken |=> !awready && !wready)
    else $error("write taken during response");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("late read response");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  reset_pass_a: assert property ($rose(aresetn) |->
    !serial_out_oe_n && serial_out == serial_in)
    else $error("no passthrough after reset");
  drive_selected_a: assert property (!select_n [*4] |-> !serial_out_oe_n)
    else $error("output floats in frame");
  shift_stable_a: assert property (link_rise |=> $stable(serial_out))
    else $error("output moved at rising edge");
endmodule // link_chk

bind serial_host_chain_interface link_chk link_chk_i (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .shift_clock, .select_n, .serial_in, .serial_out, .serial_out_oe_n);

/* sim/link_host.sv */
// Host-side model driving serial link frames
`timescale 1ns/100ps
module link_host (
  // Link pins
  output logic shift_clock,
  output logic select_n,
  output logic serial_in,
  input wire logic serial_out
);
  localparam time HALF = 160;
  initial begin
    shift_clock = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Clock stands low outside frames; idles turn cycles before bit 32
  task automatic frame(input logic [79:0] tx, input int n, input int turn,
                       output logic [79:0] rx);
    rx = 80'h0;
    select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == 32)
        repeat (turn) #(2 * HALF);
      serial_in = tx[79 - i];
      #HALF shift_clock = 1'b1;
      rx[79 - i] = serial_out;
      #HALF shift_clock = 1'b0;
    end
    select_n = 1'b1;
    serial_in = ~serial_in;
    #(8 * HALF);
  endtask
endmodule // link_host

/* sim/tb.sv */
// Self-checking bench for the serial host chain interface
`timescale 1ns/100ps
`include "serial_host_chain_map.vh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [79:0] rx;
  wire shift_clock, select_n, serial_in, serial_out, serial_out_oe_n;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 aclk = ~aclk;
  serial_host_chain_interface serial_host_chain_interface_i (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .shift_clock, .select_n,
    .serial_in, .serial_out, .serial_out_oe_n);
  // Shared output line with pull-up, floating when the device lets go
  wire shared_line = serial_out_oe_n ? 1'b1 : serial_out;
  link_host link_host_i (.shift_clock, .select_n, .serial_in, .serial_out(shared_line));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi(input bit wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    @(posedge aclk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) break;
    end
    rd = rdata;
    rs = wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic t_defaults;
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h0);
    axi(1'b0, 32'h2, 32'h0, q, r);
    chk(r, `RESP_SLVERR);
    axi(1'b1, 32'h2, 32'h8000, q, r);
    chk(r, `RESP_SLVERR);
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h0);
  endtask
  task automatic t_assign;
    link_host_i.frame({16'h2000, 16'h0, 16'h8000, 32'h0}, 48, 0, rx);
    chk(rx[79:32], {16'h2000, 16'h0, 16'h8000});
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h8000);
    link_host_i.frame({16'h2000, 16'h0, 16'h0003, 32'h0}, 48, 0, rx);
    chk(rx[79:32], 48'hFFFF_FFFF_FFFF);
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h0003);
  endtask
  task automatic t_auto;
    link_host_i.frame({16'h3180, 16'h1, 48'hA5A5_5A5A_1234}, 80, 0, rx);
    link_host_i.frame({16'h2000, 16'h1, 16'hBEEF, 32'h0}, 48, 0, rx);
    link_host_i.frame({16'h2180, 16'h2, 16'hFFFF, 32'h0}, 40, 0, rx);
    link_host_i.frame({16'hB180, 16'h1, 48'h0}, 80, 4, rx);
    chk(rx[47:0], 48'hA5A5_5A5A_1234);
  endtask
  task automatic t_shared;
    axi(1'b1, `OFS_CONTROL, 32'h4003, q, r);
    chk(r, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(serial_out_oe_n, 1'b1);
    link_host_i.frame({16'hA180, 16'h2, 16'h0, 32'h0}, 48, 4, rx);
    chk(rx[47:32], 16'h5A5A);
  endtask
  task automatic t_rereset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h0);
    chk(serial_out_oe_n, 1'b0);
    link_host_i.frame({16'h2000, 16'h0, 16'h8000, 32'h0}, 48, 0, rx);
    link_host_i.frame({16'h2000, 16'h0, 16'h0000, 32'h0}, 48, 0, rx);
    chk(rx[79:32], 48'hFFFF_FFFF_FFFF);
    axi(1'b0, `OFS_CONTROL, 32'h0, q, r);
    chk(q, 32'h0);
    chk(serial_out, serial_in);
  endtask
  task final_report;
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_assign();
    t_auto();
    t_shared();
    t_rereset();
    final_report();
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
endmodule // tb
